// file: sscl_host_model.sv
// host controller model driving the three-wire serial port
// assumes the bench clock; serial clock idles low between frames
`timescale 1ns/100ps
module sscl_host_model (
    input wire logic clock,
    output logic serial_clock,
    output logic serial_data,
    output logic load_strobe
);
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // 80 ns bit period; caller follows a denominator with a feedback write
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_data = w[i];
            tick(4);
            serial_clock = 1'b1;
            tick(4);
            serial_clock = 1'b0;
        end
        serial_data = ~w[0]; // no stale bit after the frame
        tick(2);
        load_strobe = 1'b1;
        tick(5);
        load_strobe = 1'b0;
    endtask
endmodule // sscl_host_model

// file: sscl_pkg.sv
// package for the synthesizer serial configuration latches
// assumes a single 100 MHz system clock; serial pins are asynchronous
package sscl_pkg;
    localparam int SHIFT_W = 24;
    localparam real CLK_PERIOD_NS = 10.0;
    localparam real MIN_PULSE_NS = 3.0;
    localparam int MIN_PULSE_CYC = (MIN_PULSE_NS / CLK_PERIOD_NS) < 1.0 ? 1 :
        int'($ceil(MIN_PULSE_NS / CLK_PERIOD_NS));
    // latch select codes
    localparam logic [1:0] SEL_FEEDBACK = 2'h0;
    localparam logic [1:0] SEL_REFERENCE = 2'h1;
    localparam logic [1:0] SEL_PUMP = 2'h2;
    localparam logic [1:0] SEL_NOISE = 2'h3;
    // feedback word fields
    localparam int FB_FAST_BIT = 23;
    localparam int FB_WHOLE_LSB = 14;
    localparam int FB_NUM_LSB = 2;
    // reference word fields
    localparam int RF_TIMER_BIT = 23;
    localparam int RF_MUX_LSB = 20;
    localparam int RF_PRESC_BIT = 18;
    localparam int RF_DIV_LSB = 14;
    localparam int RF_DEN_LSB = 2;
    // pump and noise word fields
    localparam int PC_DOUBLER_BIT = 12;
    localparam int PC_HALF_BIT = 11;
    localparam int PC_CUR_LSB = 7;
    localparam int PC_POL_BIT = 6;
    localparam int PC_PREC_BIT = 5;
    localparam int PC_PD_BIT = 4;
    localparam int PC_TRI_BIT = 3;
    localparam int PC_CRST_BIT = 2;
    localparam int NS_CODE_LSB = 2;
    // legal value limits
    localparam logic [8:0] WHOLE_MIN = 9'h01f;
    localparam logic [11:0] DEN_MIN = 12'h002;
    localparam logic [3:0] RDIV_MIN = 4'h1;
    // output mux codes and pump current multipliers
    localparam logic [2:0] MUX_TRISTATE = 3'h0;
    localparam logic [2:0] MUX_DIG_LOCK = 3'h1;
    localparam logic [2:0] MUX_FB_DIV = 3'h2;
    localparam logic [2:0] MUX_HIGH = 3'h3;
    localparam logic [2:0] MUX_REF_DIV = 3'h4;
    localparam logic [2:0] MUX_ANA_LOCK = 3'h5;
    localparam logic [2:0] MUX_FAST_SW = 3'h6;
    localparam logic [2:0] MUX_LOW = 3'h7;
    localparam logic [4:0] CUR_MULT_FAST = 5'h10;
    localparam logic [4:0] CUR_MULT_NORM = 5'h01;

    typedef struct packed {
        logic fast_lock_request;
        logic [8:0] whole_divide_bits;
        logic [11:0] numerator_bits;
        logic [11:0] denominator_value;
    } sscl_divider_s;

    typedef struct packed {
        logic ref_doubler;
        logic pump_half;
        logic [3:0] pump_current_code;
        logic comparator_polarity;
        logic lock_precision;
        logic power_down;
        logic pump_tristate;
        logic counter_reset;
    } sscl_pump_s;
endpackage

// file: sscl_pulse_stretch.sv
// stretches a one-cycle pulse to a minimum width
// assumes trigger is on the same clock as the counter
`timescale 1ns/100ps
module sscl_pulse_stretch import sscl_pkg::*; #(
    parameter int WIDTH = MIN_PULSE_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic trigger,
    output logic pulse
);
    initial begin
        if (WIDTH < 1 || WIDTH > 255) $error("pulse width out of range");
    end
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic pulse_reg;
    logic pulse_next;
    always_comb begin
        cnt_next = cnt_reg;
        pulse_next = 1'b0;
        if (trigger) begin
            cnt_next = 8'(WIDTH - 1);
            pulse_next = 1'b1;
        end else if (cnt_reg != 8'h00) begin
            cnt_next = cnt_reg - 8'h01;
            pulse_next = 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            pulse_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            pulse_reg <= pulse_next;
        end
    end
    assign pulse = pulse_reg;
endmodule // sscl_pulse_stretch

// file: sscl_serial_config.sv
// serial programming port, four configuration latches, test output mux
// assumes serial pins come from an asynchronous host; ref and feedback
// divider edges and lock indications come from same-clock logic
`timescale 1ns/100ps
// Summary of operation
// RULE1: word is shifted in msb first, one bit per serial clock rise.
// RULE2: load strobe rise copies the shift register into one latch.
// RULE3: the two lowest shifted bits choose the target latch.
// RULE4: 00 feedback, 01 reference, 10 pump/power, 11 noise/spur.
// RULE5: new denominator takes effect only at next feedback latch write.
// RULE6: whole value legal from 31 to 511 only.
// RULE7: reference divide code 1 to 15; zero is illegal.
// RULE8: denominator must lie from 2 to 4095.
// RULE9: host keeps numerator below the denominator.
// RULE10: ratio is whole plus numerator over denominator.
// RULE11: comparison rate is reference times doubler over divide ratio.
// RULE12: comparator output pulses last at least about 3 ns.
// RULE13: test output selected by three-bit mux code in reference latch.
// RULE14: feedback word: fast lock, whole, numerator, select 00.
// RULE15: reference word: timer load, mux, prescaler, divide, denominator.
// RULE16: pump word bits 15..0 hold doubler, current, power controls; code decodes bits 12..0 only.
// RULE17: noise word bits 10..0 hold noise and spur mode code.
// RULE18: analog lock detect output high with narrow low pulses.
// RULE19: mux codes map to tristate, locks, dividers, fixed levels.
// RULE20: timer load select steers the 12-bit field to timer or denominator.
// RULE21: fast lock raises pump current to 16x until timer expires.
// RULE22: shifting never disturbs latches; only a selecting strobe does.
module sscl_serial_config import sscl_pkg::*; #(
    parameter int WORD_W = SHIFT_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic ref_div_edge,
    input wire logic fb_div_edge,
    input wire logic ref_div_level,
    input wire logic fb_div_level,
    input wire logic digital_lock,
    input wire logic analog_lock,
    output sscl_divider_s active_divider,
    output logic [11:0] fast_lock_timer,
    output logic prescaler_select,
    output logic [3:0] reference_divide_bits,
    output sscl_pump_s pump_ctrl,
    output logic [8:0] noise_spur_code,
    output logic [4:0] pump_current_mult,
    output logic fast_lock_active,
    output logic whole_illegal,
    output logic denominator_illegal,
    output logic ref_div_illegal,
    output logic comparator_up,
    output logic comparator_down,
    output logic test_output_pin_o,
    output logic test_output_pin_oe
);
    initial begin
        if (WORD_W != SHIFT_W) $error("word width must be 24");
    end

    // two-flop synchronisers; first stage read only by second
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic sck_prev_reg;
    logic le_prev_reg;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sck_prev_reg <= 1'b0;
            le_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {serial_clock, serial_data, load_strobe};
            sync2_reg <= sync1_reg;
            sck_prev_reg <= sync2_reg[2];
            le_prev_reg <= sync2_reg[0];
        end
    end
    logic sck_rise;
    logic le_rise;
    assign sck_rise = sync2_reg[2] & ~sck_prev_reg;
    assign le_rise = sync2_reg[0] & ~le_prev_reg;

    // shift register and latches
    logic [23:0] shift_reg;
    logic [23:0] shift_next;
    sscl_divider_s div_reg;
    sscl_divider_s div_next;
    logic [11:0] den_pend_reg;
    logic [11:0] den_pend_next;
    logic [11:0] timer_reg;
    logic [11:0] timer_next;
    logic [2:0] mux_reg;
    logic [2:0] mux_next;
    logic presc_reg;
    logic presc_next;
    logic [3:0] rdiv_reg;
    logic [3:0] rdiv_next;
    sscl_pump_s pump_reg;
    sscl_pump_s pump_next;
    logic [8:0] noise_reg;
    logic [8:0] noise_next;
    logic fb_write;

    // numerator, denominator and timer share one 12-bit field shape
    function automatic logic [11:0] field12(input logic [23:0] w, input int lsb);
        return w[lsb +: 12];
    endfunction

    always_comb begin
        shift_next = shift_reg;
        div_next = div_reg;
        den_pend_next = den_pend_reg;
        timer_next = timer_reg;
        mux_next = mux_reg;
        presc_next = presc_reg;
        rdiv_next = rdiv_reg;
        pump_next = pump_reg;
        noise_next = noise_reg;
        fb_write = 1'b0;
        if (sck_rise) begin
            shift_next = {shift_reg[22:0], sync2_reg[1]}; // see RULE1
        end
        if (le_rise) begin // see RULE2 see RULE22
            unique case (shift_reg[1:0]) // see RULE3 see RULE4
                SEL_FEEDBACK: begin
                    fb_write = 1'b1;
                    div_next.fast_lock_request = shift_reg[FB_FAST_BIT]; // see RULE14
                    div_next.whole_divide_bits = shift_reg[FB_WHOLE_LSB +: 9];
                    div_next.numerator_bits = field12(shift_reg, FB_NUM_LSB);
                    div_next.denominator_value = den_pend_reg; // see RULE5
                end
                SEL_REFERENCE: begin
                    if (shift_reg[RF_TIMER_BIT]) begin // see RULE20
                        timer_next = field12(shift_reg, RF_DEN_LSB);
                    end else begin
                        den_pend_next = field12(shift_reg, RF_DEN_LSB); // see RULE15
                    end
                    mux_next = shift_reg[RF_MUX_LSB +: 3]; // see RULE13
                    presc_next = shift_reg[RF_PRESC_BIT];
                    rdiv_next = shift_reg[RF_DIV_LSB +: 4];
                end
                SEL_PUMP: begin
                    pump_next.ref_doubler = shift_reg[PC_DOUBLER_BIT]; // see RULE16
                    pump_next.pump_half = shift_reg[PC_HALF_BIT];
                    pump_next.pump_current_code = shift_reg[PC_CUR_LSB +: 4];
                    pump_next.comparator_polarity = shift_reg[PC_POL_BIT];
                    pump_next.lock_precision = shift_reg[PC_PREC_BIT];
                    pump_next.power_down = shift_reg[PC_PD_BIT];
                    pump_next.pump_tristate = shift_reg[PC_TRI_BIT];
                    pump_next.counter_reset = shift_reg[PC_CRST_BIT];
                end
                SEL_NOISE: begin
                    noise_next = shift_reg[NS_CODE_LSB +: 9]; // see RULE17
                end
            endcase
        end
    end

    // no functional reset on the device; reset here only gives sim a known state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shift_reg <= 24'h000000;
            div_reg <= '0;
            den_pend_reg <= 12'h000;
            timer_reg <= 12'h000;
            mux_reg <= MUX_TRISTATE;
            presc_reg <= 1'b0;
            rdiv_reg <= 4'h0;
            pump_reg <= '0;
            noise_reg <= 9'h000;
        end else begin
            shift_reg <= shift_next;
            div_reg <= div_next;
            den_pend_reg <= den_pend_next;
            timer_reg <= timer_next;
            mux_reg <= mux_next;
            presc_reg <= presc_next;
            rdiv_reg <= rdiv_next;
            pump_reg <= pump_next;
            noise_reg <= noise_next;
        end
    end

    // fast lock timer, counted in comparison cycles
    typedef enum {FL_IDLE, FL_RUN} sscl_fl_state_e;
    sscl_fl_state_e fl_state_reg;
    sscl_fl_state_e fl_state_next;
    logic [11:0] fl_cnt_reg;
    logic [11:0] fl_cnt_next;
    logic fl_active;
    always_comb begin
        fl_state_next = fl_state_reg;
        fl_cnt_next = fl_cnt_reg;
        if (fb_write) begin
            // every feedback write restarts or cancels the interval
            fl_state_next = div_next.fast_lock_request ? FL_RUN : FL_IDLE; // see RULE21
            fl_cnt_next = timer_reg;
        end else begin
            unique case (fl_state_reg)
                FL_IDLE: fl_state_next = FL_IDLE;
                FL_RUN: begin
                    // a timer of n ends the interval at the n-th comparison edge
                    if (ref_div_edge && fl_cnt_reg > 12'h001) begin
                        fl_cnt_next = fl_cnt_reg - 12'h001;
                    end else if (ref_div_edge) begin
                        fl_state_next = FL_IDLE; // see RULE21
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fl_state_reg <= FL_IDLE;
            fl_cnt_reg <= 12'h000;
        end else begin
            fl_state_reg <= fl_state_next;
            fl_cnt_reg <= fl_cnt_next;
        end
    end
    assign fl_active = fl_state_reg == FL_RUN;

    // phase comparator with minimum pulse width
    logic up_state_reg;
    logic up_state_next;
    logic dn_state_reg;
    logic dn_state_next;
    logic reset_pulse;
    logic up_raw;
    logic dn_raw;
    always_comb begin
        up_state_next = up_state_reg | ref_div_edge;
        dn_state_next = dn_state_reg | fb_div_edge;
        if (up_state_next && dn_state_next) begin
            up_state_next = 1'b0;
            dn_state_next = 1'b0;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            up_state_reg <= 1'b0;
            dn_state_reg <= 1'b0;
        end else begin
            up_state_reg <= up_state_next;
            dn_state_reg <= dn_state_next;
        end
    end
    // both outputs get a guaranteed minimum pulse: removes the dead zone
    assign reset_pulse = (up_state_reg | ref_div_edge) & (dn_state_reg | fb_div_edge);
    sscl_pulse_stretch #(.WIDTH(MIN_PULSE_CYC)) u_stretch (
        .clock(clock),
        .rst_n(rst_n),
        .trigger(reset_pulse),
        .pulse(up_raw)
    ); // see RULE12
    assign dn_raw = up_raw;

    // polarity swaps up and down; pulse state from the next values
    logic up_o_reg;
    logic dn_o_reg;
    logic up_o_next;
    logic dn_o_next;
    logic tp_reg;
    logic tp_next;
    logic tp_oe_reg;
    logic tp_oe_next;
    always_comb begin
        up_o_next = (up_state_next & ~dn_state_next) | up_raw;
        dn_o_next = (dn_state_next & ~up_state_next) | dn_raw;
        tp_next = 1'b0;
        tp_oe_next = 1'b1;
        unique case (mux_reg) // see RULE19
            MUX_TRISTATE: tp_oe_next = 1'b0;
            MUX_DIG_LOCK: tp_next = digital_lock;
            MUX_FB_DIV: tp_next = fb_div_level;
            MUX_HIGH: tp_next = 1'b1;
            MUX_REF_DIV: tp_next = ref_div_level;
            MUX_ANA_LOCK: begin
                // open drain: pull low on pulses, release when locked; see RULE18
                tp_oe_next = ~(analog_lock & ~up_raw);
                tp_next = 1'b0;
            end
            MUX_FAST_SW: tp_next = fl_active;
            MUX_LOW: tp_next = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            up_o_reg <= 1'b0;
            dn_o_reg <= 1'b0;
            tp_reg <= 1'b0;
            tp_oe_reg <= 1'b0;
        end else begin
            up_o_reg <= up_o_next;
            dn_o_reg <= dn_o_next;
            tp_reg <= tp_next;
            tp_oe_reg <= tp_oe_next;
        end
    end
    assign comparator_up = pump_reg.comparator_polarity ? up_o_reg : dn_o_reg;
    assign comparator_down = pump_reg.comparator_polarity ? dn_o_reg : up_o_reg;
    assign test_output_pin_o = tp_reg; // see RULE13
    assign test_output_pin_oe = tp_oe_reg;

    // ratio and comparison rate settings leave as registered fields; see RULE10 see RULE11
    assign active_divider = div_reg;
    assign fast_lock_timer = timer_reg;
    assign prescaler_select = presc_reg;
    assign reference_divide_bits = rdiv_reg;
    assign pump_ctrl = pump_reg;
    assign noise_spur_code = noise_reg;
    assign fast_lock_active = fl_active;
    assign pump_current_mult = fl_active ? CUR_MULT_FAST : CUR_MULT_NORM; // see RULE21
    // legality flags only report; the device stores illegal values as given
    // judged from the next values so each flag moves with its latch
    logic whole_ill_reg;
    logic whole_ill_next;
    logic den_ill_reg;
    logic den_ill_next;
    logic rdiv_ill_reg;
    logic rdiv_ill_next;
    always_comb begin
        whole_ill_next = div_next.whole_divide_bits < WHOLE_MIN; // see RULE6
        den_ill_next = div_next.denominator_value < DEN_MIN; // see RULE8
        rdiv_ill_next = rdiv_next < RDIV_MIN; // see RULE7
    end

    // reset contents are all zero, which every limit calls illegal
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            whole_ill_reg <= 1'b1;
            den_ill_reg <= 1'b1;
            rdiv_ill_reg <= 1'b1;
        end else begin
            whole_ill_reg <= whole_ill_next;
            den_ill_reg <= den_ill_next;
            rdiv_ill_reg <= rdiv_ill_next;
        end
    end
    assign whole_illegal = whole_ill_reg;
    assign denominator_illegal = den_ill_reg;
    assign ref_div_illegal = rdiv_ill_reg;
endmodule // sscl_serial_config

// file: sscl_serial_config_properties.sv
// port assertions for the serial configuration block
// assumes a bind from the testbench and the one system clock domain
`timescale 1ns/100ps
module sscl_serial_checker import sscl_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load_strobe,
    input wire sscl_divider_s active_divider,
    input wire logic [11:0] fast_lock_timer,
    input wire logic prescaler_select,
    input wire logic [3:0] reference_divide_bits,
    input wire sscl_pump_s pump_ctrl,
    input wire logic [8:0] noise_spur_code,
    input wire logic [4:0] pump_current_mult,
    input wire logic fast_lock_active,
    input wire logic whole_illegal,
    input wire logic ref_div_illegal
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // strobe is held several clocks, so a fixed look-back finds it
    property p_div_needs_strobe;
        $changed(active_divider) |-> $past(load_strobe, 3);
    endproperty
    a_div_needs_strobe: assert property (p_div_needs_strobe) else $error("divider moved");
    property p_ref_needs_strobe;
        $changed({fast_lock_timer, prescaler_select, reference_divide_bits})
            |-> $past(load_strobe, 3);
    endproperty
    a_ref_needs_strobe: assert property (p_ref_needs_strobe) else $error("ref moved");
    property p_pump_needs_strobe;
        $changed({pump_ctrl, noise_spur_code}) |-> $past(load_strobe, 3);
    endproperty
    a_pump_needs_strobe: assert property (p_pump_needs_strobe) else $error("pump moved");
    property p_quiet_hold;
        !load_strobe [*7] |=> $stable(active_divider) && $stable(pump_ctrl)
            && $stable(noise_spur_code) && $stable(fast_lock_timer);
    endproperty
    a_quiet_hold: assert property (p_quiet_hold) else $error("latch moved idle");
    property p_mult;
        pump_current_mult == (fast_lock_active ? CUR_MULT_FAST : CUR_MULT_NORM);
    endproperty
    a_mult: assert property (p_mult) else $error("pump multiplier wrong");
    property p_fast_start;
        $rose(fast_lock_active) |-> active_divider.fast_lock_request;
    endproperty
    a_fast_start: assert property (p_fast_start) else $error("fast lock unrequested");
    property p_whole;
        whole_illegal == (active_divider.whole_divide_bits < WHOLE_MIN);
    endproperty
    a_whole: assert property (p_whole) else $error("whole flag wrong");
    property p_ref_ill;
        ref_div_illegal == (reference_divide_bits == 4'h0);
    endproperty
    a_ref_ill: assert property (p_ref_ill) else $error("ref divide flag wrong");
endmodule // sscl_serial_checker

// file: testbench.sv
// top bench: host model drives the serial port, tasks judge the latches
// assumes 100 MHz clock and the checker bound below
`timescale 1ns/100ps
module testbench import sscl_pkg::*; ();
    logic clock = 1'b0, rst_n = 1'b0, ref_div_edge = 1'b0, fb_div_edge = 1'b0;
    logic ref_div_level = 1'b1, fb_div_level = 1'b0, digital_lock = 1'b1, analog_lock = 1'b1;
    wire logic serial_clock, serial_data, load_strobe;
    sscl_divider_s active_divider;
    sscl_pump_s pump_ctrl;
    logic [11:0] fast_lock_timer;
    logic [3:0] reference_divide_bits;
    logic [8:0] noise_spur_code;
    logic [4:0] pump_current_mult;
    logic prescaler_select, fast_lock_active, whole_illegal, denominator_illegal;
    logic ref_div_illegal, comparator_up, comparator_down, test_output_pin_o, test_output_pin_oe;
    int miscompares = 0, cmp_count = 0;

    sscl_serial_config dut (.*);
    sscl_host_model host (.clock(clock), .serial_clock(serial_clock),
        .serial_data(serial_data), .load_strobe(load_strobe));

    always #5 clock = ~clock;

    task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic put(input logic [23:0] w);
        host.send(w);
        repeat (8) @(posedge clock);
        #1;
    endtask
    function automatic logic [23:0] fb_w(logic f, logic [8:0] wh, logic [11:0] nm);
        return {f, wh, nm, SEL_FEEDBACK};
    endfunction
    function automatic logic [23:0] rf_w(logic t, logic [2:0] m, logic p, logic [3:0] r,
        logic [11:0] v);
        return {t, m, 1'b0, p, r, v, SEL_REFERENCE};
    endfunction
    task automatic s_feedback;
        put(rf_w(1'b0, MUX_TRISTATE, 1'b0, 4'h1, 12'h005));
        check(active_divider.denominator_value, 0, "den pending");
        put(fb_w(1'b0, 9'h01f, 12'h004));
        check(active_divider, {1'b0, 9'h01f, 12'h004, 12'h005}, "divider");
        check(whole_illegal, 0, "whole 31");
        check(denominator_illegal, 0, "den 5");
        put(rf_w(1'b0, MUX_TRISTATE, 1'b0, 4'h1, 12'h001));
        put(fb_w(1'b0, 9'h01e, 12'h000));
        check(whole_illegal, 1, "whole 30");
        check(denominator_illegal, 1, "den 1");
    endtask
    task automatic s_reference;
        put(rf_w(1'b0, MUX_TRISTATE, 1'b1, 4'hf, 12'hfff));
        check({prescaler_select, reference_divide_bits}, 5'h1f, "presc rdiv");
        check(ref_div_illegal, 0, "rdiv 15");
        put(rf_w(1'b1, MUX_TRISTATE, 1'b0, 4'h0, 12'h003));
        check(fast_lock_timer, 12'h003, "timer");
        check(ref_div_illegal, 1, "rdiv 0");
        put(fb_w(1'b0, 9'h1ff, 12'h000));
        check(active_divider, {1'b0, 9'h1ff, 12'h000, 12'hfff}, "timer spares den");
    endtask
    task automatic s_latches;
        put({11'h000, 11'h5a5, SEL_PUMP});
        check(pump_ctrl, 11'h5a5, "pump");
        put({13'h0000, 9'h1c7, SEL_NOISE});
        check(noise_spur_code, 9'h1c7, "noise");
        check(pump_ctrl, 11'h5a5, "pump kept");
        check(active_divider, {1'b0, 9'h1ff, 12'h000, 12'hfff}, "divider kept");
    endtask
    task automatic s_mux;
        // digital lock held high; no fast lock requested yet, so switch reads low
        logic [1:0] e [8] = '{2'b00, 2'b11, 2'b10, 2'b11, 2'b11, 2'b00, 2'b10, 2'b10};
        for (int i = 0; i < 8; i++) begin
            put(rf_w(1'b0, 3'(i), 1'b0, 4'h1, 12'hfff));
            check(test_output_pin_oe ? {test_output_pin_oe, test_output_pin_o} : 2'b00,
                e[i], "mux pin");
        end
    endtask
    task automatic edge_pulse;
        ref_div_edge = 1'b1;
        @(posedge clock);
        #1;
        ref_div_edge = 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic s_fastlock;
        put(rf_w(1'b1, MUX_TRISTATE, 1'b0, 4'h1, 12'h003));
        put(fb_w(1'b1, 9'h040, 12'h000));
        check({fast_lock_active, pump_current_mult}, {1'b1, CUR_MULT_FAST}, "fast on");
        repeat (2) edge_pulse();
        check(fast_lock_active, 1, "fast held");
        edge_pulse();
        check({fast_lock_active, pump_current_mult}, {1'b0, CUR_MULT_NORM}, "fast off");
    endtask
    task automatic pfd_edges(input logic r, input logic f);
        ref_div_edge = r;
        fb_div_edge = f;
        @(posedge clock);
        #1;
    endtask
    task automatic s_comparator;
        put(rf_w(1'b0, MUX_ANA_LOCK, 1'b0, 4'h1, 12'hfff));
        put({11'h000, 11'h010, SEL_PUMP});
        pfd_edges(1'b1, 1'b0);
        check({comparator_up, comparator_down}, 2'b10, "pfd lead");
        pfd_edges(1'b0, 1'b1);
        check({comparator_up, comparator_down}, 2'b00, "pfd cleared");
        pfd_edges(1'b0, 1'b0);
        check({comparator_up, comparator_down, test_output_pin_oe, test_output_pin_o},
            4'b1110, "min pulse pin low");
        pfd_edges(1'b0, 1'b0);
        check({comparator_up, comparator_down, test_output_pin_oe, test_output_pin_o},
            4'b0000, "pfd idle pin high");
    endtask

    initial begin
        repeat (5) @(posedge clock);
        #1;
        rst_n = 1'b1;
        check({active_divider, test_output_pin_oe}, 0, "reset state");
        s_feedback();
        s_reference();
        s_latches();
        s_mux();
        s_fastlock();
        s_comparator();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        complete_run();
    end
endmodule // testbench

bind sscl_serial_config sscl_serial_checker chk_i (.*);
